// [sock_defines.svh]
// Offsets, field positions, codes and reset values of the socket block
`ifndef SOCK_DEFINES_SVH
`define SOCK_DEFINES_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define OFS_COMMAND 16'h0001
`define OFS_EVENT_FLAGS 16'h0002
`define OFS_SOCKET_STATE 16'h0003
`define OFS_EVENT_MASK 16'h0020

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define EVENT_FLAGS_RESET 8'h00
`define EVENT_MASK_RESET 8'h1f

// ----------------------------------------------------------------------
// Event flag bit positions
// ----------------------------------------------------------------------
`define FLAG_LINK_UP 0
`define FLAG_PEER_FIN 1
`define FLAG_DATA_IN 2
`define FLAG_EXPIRY 3
`define FLAG_SEND_DONE 4
`define FLAG_COUNT 5

// ----------------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------------
`define CODE_TEARDOWN 8'h08
`define CODE_CLOSE 8'h10
`define CODE_SEND 8'h20
`define CODE_SEND_PRESET 8'h21
`define CODE_KEEPALIVE 8'h22
`define CODE_RECEIVE_DONE 8'h40

// ----------------------------------------------------------------------
// Socket state codes and keep-alive payload
// ----------------------------------------------------------------------
`define STATE_RELEASED 8'h00
`define STATE_CONNECTED 8'h17
`define STATE_FIN_WAIT 8'h18
`define STATE_CLOSE_WAIT 8'h1c
`define STATE_LAST_ACK 8'h1d
`define KEEPALIVE_BYTES 8'h01

`endif

// [sock_pkg.sv]
// Types shared by the socket command and event flag modules
`default_nettype none
`include "sock_defines.svh"
package sock_pkg;
  typedef enum logic [4:0] {
    fsm_idle = 5'b0_0001,
    fsm_resolve = 5'b0_0010,
    fsm_send = 5'b0_0100,
    fsm_fin = 5'b0_1000,
    fsm_keep = 5'b1_0000
  } fsm_type;

  typedef enum logic [3:0] {
    mode_closed = 4'h0,
    mode_tcp = 4'h1,
    mode_udp = 4'h2,
    mode_raw = 4'h4
  } mode_type;
endpackage
`default_nettype wire

// [sock_evt_if.sv]
// Event pulses, mask and clear path between command logic and flag store
`default_nettype none
`include "sock_defines.svh"
interface sock_evt_if;
  logic [`FLAG_COUNT-1:0] event_pulse;
  logic [7:0] mask;
  logic clear_wr;
  logic [7:0] clear_data;
  logic [7:0] flags;

  modport source (
    output event_pulse,
    output mask,
    output clear_wr,
    output clear_data,
    input flags
  );
  modport keeper (
    input event_pulse,
    input mask,
    input clear_wr,
    input clear_data,
    output flags
  );
endinterface
`default_nettype wire

// [event_flags.sv]
// Sticky, masked, write-one-to-clear socket event flags
`default_nettype none
`include "sock_defines.svh"
module event_flags (
  input wire logic clk,
  input wire logic rst,
  sock_evt_if.keeper evt
);
  import sock_pkg::*;

  logic [`FLAG_COUNT-1:0] held;
  logic [`FLAG_COUNT-1:0] next_held;
  wire [`FLAG_COUNT-1:0] gated_set = evt.event_pulse &
    evt.mask[`FLAG_COUNT-1:0];
  wire [`FLAG_COUNT-1:0] clear_bits = evt.clear_wr ?
    evt.clear_data[`FLAG_COUNT-1:0] : '0;

  // Set beats a same-cycle clear so no event is lost
  assign next_held = (held & ~clear_bits) | gated_set;
  assign evt.flags = {3'b000, held};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      held <= `FLAG_COUNT'(`EVENT_FLAGS_RESET);
    end else begin
      held <= next_held;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  mask_gate_a: assert property (@(posedge clk) disable iff (rst)
    ((held & ~$past(held) & ~$past(gated_set)) == '0))
    else $error("flag rose without a masked event");
  set_wins_a: assert property (@(posedge clk) disable iff (rst)
    (gated_set != '0) |=> ((held & $past(gated_set)) == $past(gated_set)))
    else $error("masked event lost");
  zero_write_a: assert property (@(posedge clk) disable iff (rst)
    (!evt.clear_wr) |=> ((held & $past(held)) == $past(held)))
    else $error("flag dropped without a clear write");
endmodule
`default_nettype wire

// [cmd_check.sv]
// Command validity against socket mode and state
`default_nettype none
`include "sock_defines.svh"
module cmd_check (
  input wire logic [7:0] code,
  input wire sock_pkg::mode_type mode,
  input wire logic [7:0] state,
  output logic ok_teardown,
  output logic ok_close,
  output logic ok_send,
  output logic ok_send_preset,
  output logic ok_keepalive,
  output logic ok_receive_done
);
  import sock_pkg::*;

  wire is_tcp = (mode == mode_tcp);
  wire is_udp = (mode == mode_udp);
  wire tcp_open = is_tcp && (state == `STATE_CONNECTED ||
    state == `STATE_CLOSE_WAIT);

  assign ok_teardown = (code == `CODE_TEARDOWN) && is_tcp;
  assign ok_close = (code == `CODE_CLOSE);
  assign ok_send = (code == `CODE_SEND) && (is_udp || tcp_open);
  assign ok_send_preset = (code == `CODE_SEND_PRESET) && is_udp;
  assign ok_keepalive = (code == `CODE_KEEPALIVE) && is_tcp &&
    (state == `STATE_CONNECTED);
  assign ok_receive_done = (code == `CODE_RECEIVE_DONE);
endmodule
`default_nettype wire

// [socket_cmd.sv]
// Socket command interpreter, state keeping and event sources
// What this block does
// - Code 0x08 starts disconnect, server or client, only in TCP mode.
// - Active close sends a FIN to the connected peer.
// - Passive close, after peer FIN, answers with our own FIN.
// - Received FIN/ACK completes disconnect and releases the socket.
// - Failed disconnect raises TCP timeout, sets flag 3, then releases.
// - Code 0x10 releases the socket at once, with no packets.
// - RST from peer during communication forces the released state.
// - Code 0x20 sends all pending transmit buffer data.
// - Normal send first resolves the destination hardware address.
// - Code 0x21, UDP only, sends using host-written hardware address.
// - Code 0x22, TCP only, sends a one-byte keep-alive packet.
// - No keep-alive answer before timeout ends connection, raises timeout.
// - Code 0x40 frees receive space up to host read pointer.
// - A flag sets only on its event with its mask bit one.
// - Flag 4 sets when a send completes.
// - Flag 3 sets on resolution or TCP retry timeout.
// - Flag 2 sets whenever data arrives from the peer.
// - Flag 1 sets when FIN or FIN/ACK arrives.
// - Flag 0 sets once as the state becomes connected.
// - Peer RST, close or TCP timeout enter released from any state.
`default_nettype none
`include "sock_defines.svh"
module socket_cmd (
  input wire logic clk,
  input wire logic rst,
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire sock_pkg::mode_type sock_mode,
  input wire logic state_load,
  input wire logic [7:0] state_load_value,
  input wire logic rx_fin_seen,
  input wire logic rx_finack_seen,
  input wire logic rx_rst_seen,
  input wire logic rx_data_seen,
  input wire logic peer_ack_seen,
  input wire logic resolve_done,
  input wire logic resolution_retry_expiry,
  input wire logic tcp_retry_expiry,
  input wire logic tx_done,
  input wire logic [15:0] rx_read_pointer,
  output logic fin_tx_req,
  output logic keepalive_tx_req,
  output logic [7:0] keepalive_len,
  output logic resolve_req,
  output logic tx_start,
  output logic use_preset_dest,
  output logic rx_release,
  output logic [15:0] rx_done_pointer,
  output logic [7:0] socket_state,
  output logic busy
);
  import sock_pkg::*;

  // ----------------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------------
  wire cmd_wr = reg_wr && (reg_addr == `OFS_COMMAND);
  wire flags_wr = reg_wr && (reg_addr == `OFS_EVENT_FLAGS);
  wire mask_wr = reg_wr && (reg_addr == `OFS_EVENT_MASK);

  fsm_type fsm;
  fsm_type next_fsm;
  logic [7:0] next_state;
  logic [7:0] socket_event_mask;
  logic ok_teardown;
  logic ok_close;
  logic ok_send;
  logic ok_send_preset;
  logic ok_keepalive;
  logic ok_receive_done;

  sock_evt_if evt ();

  cmd_check mode_check (
    .code(reg_wdata),
    .mode(sock_mode),
    .state(socket_state),
    .ok_teardown(ok_teardown),
    .ok_close(ok_close),
    .ok_send(ok_send),
    .ok_send_preset(ok_send_preset),
    .ok_keepalive(ok_keepalive),
    .ok_receive_done(ok_receive_done)
  );

  event_flags flag_store (
    .clk(clk),
    .rst(rst),
    .evt(evt.keeper)
  );

  // Only one sequence runs at a time; a busy socket ignores new
  // sequence commands, while close and receive-done act at any time.
  wire idle = (fsm == fsm_idle);
  wire go_teardown = cmd_wr && ok_teardown && idle;
  wire go_close = cmd_wr && ok_close;
  wire go_send = cmd_wr && ok_send && idle;
  wire go_send_preset = cmd_wr && ok_send_preset && idle;
  wire go_keepalive = cmd_wr && ok_keepalive && idle;
  wire go_receive_done = cmd_wr && ok_receive_done;
  wire passive_close = (socket_state == `STATE_CLOSE_WAIT);
  wire peer_reset = rx_rst_seen && (socket_state != `STATE_RELEASED);
  wire any_expiry = tcp_retry_expiry || resolution_retry_expiry;

  // ----------------------------------------------------------------------
  // Sequencer and socket state
  // ----------------------------------------------------------------------
  always_comb begin
    next_fsm = fsm;
    next_state = socket_state;
    if (state_load && idle) begin
      next_state = state_load_value;
    end
    if (rx_fin_seen && socket_state == `STATE_CONNECTED) begin
      next_state = `STATE_CLOSE_WAIT;
    end
    case (fsm)
      fsm_idle: begin
        if (go_teardown) begin
          next_fsm = fsm_fin;
          next_state = passive_close ? `STATE_LAST_ACK : `STATE_FIN_WAIT;
        end else if (go_send) begin
          next_fsm = fsm_resolve;
        end else if (go_send_preset) begin
          next_fsm = fsm_send;
        end else if (go_keepalive) begin
          next_fsm = fsm_keep;
        end
      end
      fsm_resolve: begin
        if (resolve_done) begin
          next_fsm = fsm_send;
        end else if (resolution_retry_expiry) begin
          next_fsm = fsm_idle;
        end
      end
      fsm_send: begin
        if (tx_done) begin
          next_fsm = fsm_idle;
        end
      end
      fsm_fin: begin
        if (rx_finack_seen) begin
          next_fsm = fsm_idle;
          next_state = `STATE_RELEASED;
        end
      end
      fsm_keep: begin
        if (peer_ack_seen) begin
          next_fsm = fsm_idle;
        end
      end
      default: begin
        next_fsm = fsm_idle;
      end
    endcase
    // TCP retry expiry ends disconnect, keep-alive or any live connection
    if (tcp_retry_expiry) begin
      next_fsm = fsm_idle;
      next_state = `STATE_RELEASED;
    end
    if (go_close || peer_reset) begin
      next_fsm = fsm_idle;
      next_state = `STATE_RELEASED;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fsm <= fsm_idle;
      socket_state <= `STATE_RELEASED;
    end else begin
      fsm <= next_fsm;
      socket_state <= next_state;
    end
  end

  // ----------------------------------------------------------------------
  // Requests toward the packet engine
  // ----------------------------------------------------------------------
  wire enter_send = (next_fsm == fsm_send) && (fsm != fsm_send);
  wire enter_resolve = (next_fsm == fsm_resolve) && (fsm != fsm_resolve);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fin_tx_req <= 1'b0;
      keepalive_tx_req <= 1'b0;
      resolve_req <= 1'b0;
      tx_start <= 1'b0;
      rx_release <= 1'b0;
    end else begin
      fin_tx_req <= go_teardown && (next_fsm == fsm_fin);
      keepalive_tx_req <= go_keepalive && (next_fsm == fsm_keep);
      resolve_req <= enter_resolve;
      tx_start <= enter_send;
      rx_release <= go_receive_done;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      use_preset_dest <= 1'b0;
      rx_done_pointer <= 16'h0000;
    end else begin
      if (go_send_preset && next_fsm == fsm_send) begin
        use_preset_dest <= 1'b1;
      end else if (go_send && next_fsm == fsm_resolve) begin
        use_preset_dest <= 1'b0;
      end
      if (go_receive_done) begin
        rx_done_pointer <= rx_read_pointer;
      end
    end
  end

  assign keepalive_len = `KEEPALIVE_BYTES;
  assign busy = !idle;

  // ----------------------------------------------------------------------
  // Event sources and register file
  // ----------------------------------------------------------------------
  assign evt.event_pulse[`FLAG_LINK_UP] = (next_state == `STATE_CONNECTED)
    && (socket_state != `STATE_CONNECTED);
  assign evt.event_pulse[`FLAG_PEER_FIN] = rx_fin_seen ||
    rx_finack_seen;
  assign evt.event_pulse[`FLAG_DATA_IN] = rx_data_seen;
  assign evt.event_pulse[`FLAG_EXPIRY] = any_expiry;
  assign evt.event_pulse[`FLAG_SEND_DONE] = (fsm == fsm_send) &&
    tx_done;
  assign evt.mask = socket_event_mask;
  assign evt.clear_wr = flags_wr;
  assign evt.clear_data = reg_wdata;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      socket_event_mask <= `EVENT_MASK_RESET;
    end else if (mask_wr) begin
      socket_event_mask <= reg_wdata;
    end
  end

  // Command register reads zero: commands act once and self-clear
  wire [7:0] read_mux =
    (reg_addr == `OFS_EVENT_FLAGS) ? evt.flags :
    (reg_addr == `OFS_SOCKET_STATE) ? socket_state :
    (reg_addr == `OFS_EVENT_MASK) ? socket_event_mask : 8'h00;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= read_mux;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  close_release_a: assert property (
    go_close |=> socket_state == `STATE_RELEASED && !fin_tx_req)
    else $error("close did not release silently");
  peer_reset_a: assert property (
    peer_reset |=> socket_state == `STATE_RELEASED)
    else $error("peer reset did not release socket");
  fin_issue_a: assert property (
    go_teardown && !go_close && !peer_reset && !tcp_retry_expiry
    |=> fin_tx_req ##1 !fin_tx_req)
    else $error("disconnect did not send one FIN");
  passive_fin_a: assert property (
    go_teardown && passive_close && !tcp_retry_expiry && !peer_reset
    |=> socket_state == `STATE_LAST_ACK)
    else $error("passive close did not reply FIN");
  mode_guard_a: assert property (
    cmd_wr && reg_wdata == `CODE_TEARDOWN && sock_mode != mode_tcp
    |=> !fin_tx_req)
    else $error("disconnect honoured outside TCP");
  finack_done_a: assert property (
    fsm == fsm_fin && rx_finack_seen |=> socket_state == `STATE_RELEASED
    && fsm == fsm_idle)
    else $error("FIN/ACK did not release socket");
  expiry_end_a: assert property (
    tcp_retry_expiry |=> socket_state == `STATE_RELEASED
    && fsm == fsm_idle)
    else $error("timeout did not release socket");
  resolve_first_a: assert property (
    tx_start && !use_preset_dest |-> $past(fsm) == fsm_resolve)
    else $error("send started without resolution");
  preset_skip_a: assert property (
    go_send_preset && !go_close && !peer_reset && !tcp_retry_expiry
    |=> tx_start && !resolve_req && use_preset_dest)
    else $error("preset send did not skip resolution");
  cmd_receive_done_pointer_a: assert property (
    go_receive_done |=> rx_release &&
    rx_done_pointer == $past(rx_read_pointer))
    else $error("receive-done pointer not taken");
  invalid_quiet_a: assert property (
    cmd_wr && !ok_close && !(ok_teardown || ok_send || ok_send_preset ||
    ok_keepalive) && idle && !state_load && !rx_fin_seen && !peer_reset
    && !tcp_retry_expiry |=> fsm == fsm_idle && $stable(socket_state))
    else $error("invalid command changed state");
endmodule
`default_nettype wire

// [remote_peer.sv]
// Behavioural model of the remote network peer facing the socket block
`default_nettype none
module remote_peer (
  input wire logic clk,
  input wire logic rst,
  input wire logic fin_tx_req,
  input wire logic keepalive_tx_req,
  input wire logic [7:0] keepalive_len,
  input wire logic resolve_req,
  input wire logic tx_start,
  input wire logic silent,
  input wire logic [3:0] delay,
  output logic rx_finack_seen,
  output logic peer_ack_seen,
  output logic resolve_done,
  output logic tx_done
);
  timeunit 1ns;
  timeprecision 1ps;
  logic pending;
  logic [1:0] kind;
  logic [3:0] left;
  // One outstanding answer only; the block runs one sequence at a time
  always @(negedge clk or posedge rst) begin
    if (rst) begin
      pending <= 1'b0;
      kind <= 2'd0;
      left <= 4'd0;
      {rx_finack_seen, peer_ack_seen, resolve_done, tx_done} <= 4'b0;
    end else begin
      {rx_finack_seen, peer_ack_seen, resolve_done, tx_done} <= 4'b0;
      if (pending && left == 4'd0) begin
        pending <= 1'b0;
        case (kind)
          2'd0: rx_finack_seen <= 1'b1;
          2'd1: peer_ack_seen <= 1'b1;
          2'd2: resolve_done <= 1'b1;
          default: tx_done <= 1'b1;
        endcase
      end else if (pending) begin
        left <= left - 4'd1;
      end
      // A silent peer models a lost link: new requests get no answer of any kind
      if (!silent) begin
        if (fin_tx_req) begin
          pending <= 1'b1;
          kind <= 2'd0;
          left <= delay;
        end
        // Malformed probe goes unanswered, as a real peer would
        if (keepalive_tx_req && keepalive_len == 8'h01) begin
          pending <= 1'b1;
          kind <= 2'd1;
          left <= delay;
        end
        if (resolve_req) begin
          pending <= 1'b1;
          kind <= 2'd2;
          left <= delay;
        end
        if (tx_start) begin
          pending <= 1'b1;
          kind <= 2'd3;
          left <= delay;
        end
      end
    end
  end
endmodule
`default_nettype wire

// [socket_cmd_tb_top.sv]
// Self-checking bench for the socket command and event flag block
`default_nettype none
`include "sock_defines.svh"
module socket_cmd_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import sock_pkg::*;
  logic clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [15:0] reg_addr = 16'h0000, rx_read_pointer = 16'h0000;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, state_load_value = 8'h00;
  mode_type sock_mode = mode_tcp;
  logic state_load = 1'b0, rx_fin_seen = 1'b0, rx_rst_seen = 1'b0;
  logic rx_data_seen = 1'b0, res_exp = 1'b0, tcp_exp = 1'b0;
  logic silent = 1'b0;
  logic [3:0] delay = 4'd2;
  logic finack, pack, rdone, txdone, fin_req, keep_req, res_req, tx_go;
  logic preset, rx_rel, busy;
  logic [7:0] keep_len, socket_state;
  logic [15:0] done_ptr;
  logic [15:0] n_fin = 16'h0, n_res = 16'h0, n_tx = 16'h0, n_keep = 16'h0;
  logic [15:0] n_rel = 16'h0, snap;
  logic preset_seen = 1'b0;
  int num_errors = 0, check_count = 0, cycles = 0;

  socket_cmd u_socket_cmd (.clk(clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .sock_mode(sock_mode), .state_load(state_load),
    .state_load_value(state_load_value), .rx_fin_seen(rx_fin_seen),
    .rx_finack_seen(finack), .rx_rst_seen(rx_rst_seen),
    .rx_data_seen(rx_data_seen), .peer_ack_seen(pack),
    .resolve_done(rdone), .resolution_retry_expiry(res_exp),
    .tcp_retry_expiry(tcp_exp), .tx_done(txdone),
    .rx_read_pointer(rx_read_pointer), .fin_tx_req(fin_req),
    .keepalive_tx_req(keep_req), .keepalive_len(keep_len),
    .resolve_req(res_req), .tx_start(tx_go), .use_preset_dest(preset),
    .rx_release(rx_rel), .rx_done_pointer(done_ptr),
    .socket_state(socket_state), .busy(busy));

  remote_peer u_remote_peer (.clk(clk), .rst(rst), .fin_tx_req(fin_req),
    .keepalive_tx_req(keep_req), .keepalive_len(keep_len),
    .resolve_req(res_req), .tx_start(tx_go), .silent(silent),
    .delay(delay), .rx_finack_seen(finack), .peer_ack_seen(pack),
    .resolve_done(rdone), .tx_done(txdone));

  initial begin
    forever #2.5 clk = ~clk;
  end

  // ----------------------------------------------------------------------
  // Request pulse counters and run limit
  // ----------------------------------------------------------------------
  always @(posedge clk) begin
    if (fin_req === 1'b1) n_fin <= n_fin + 16'h1;
    if (res_req === 1'b1) n_res <= n_res + 16'h1;
    if (keep_req === 1'b1) n_keep <= n_keep + 16'h1;
    if (rx_rel === 1'b1) n_rel <= n_rel + 16'h1;
    if (tx_go === 1'b1) begin
      n_tx <= n_tx + 16'h1;
      preset_seen <= preset;
    end
    cycles <= cycles + 1;
    if (cycles >= 4000) begin
      num_errors++;
      conclude;
    end
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    // Let the request pulse of this write reach the counters
    @(negedge clk);
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    check({8'h00, reg_rdata}, {8'h00, exp});
  endtask

  task automatic pulse(ref logic s);
    @(negedge clk);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask

  task automatic load(input logic [7:0] v);
    state_load_value = v;
    pulse(state_load);
    wr(`OFS_EVENT_FLAGS, 8'hff);
  endtask

  task automatic settle;
    for (int i = 0; i < 60; i++) begin
      if (busy === 1'b0) break;
      @(negedge clk);
    end
    check({15'h0, busy}, 16'h0);
  endtask

  task automatic conclude;
    if (num_errors == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk);
    @(negedge clk) rst = 1'b0;
    rd(`OFS_EVENT_FLAGS, `EVENT_FLAGS_RESET);
    rd(`OFS_EVENT_MASK, `EVENT_MASK_RESET);
    rd(`OFS_SOCKET_STATE, `STATE_RELEASED);
    rd(16'h0000, 8'h00);
    rd(`OFS_COMMAND, 8'h00);
    state_load_value = `STATE_CONNECTED;
    pulse(state_load);
    rd(`OFS_EVENT_FLAGS, 8'h01);
    wr(`OFS_EVENT_FLAGS, 8'h00);
    rd(`OFS_EVENT_FLAGS, 8'h01);
    wr(`OFS_EVENT_FLAGS, 8'he1);
    rd(`OFS_EVENT_FLAGS, 8'h00);
    snap = n_fin;
    wr(`OFS_COMMAND, `CODE_TEARDOWN);
    settle;
    check(n_fin, snap + 16'h1);
    rd(`OFS_SOCKET_STATE, `STATE_RELEASED);
    rd(`OFS_EVENT_FLAGS, 8'h02);
    // Slow peer so the intermediate state is visible
    delay = 4'd9;
    load(`STATE_CONNECTED);
    pulse(rx_fin_seen);
    rd(`OFS_SOCKET_STATE, `STATE_CLOSE_WAIT);
    snap = n_fin;
    wr(`OFS_COMMAND, `CODE_TEARDOWN);
    rd(`OFS_SOCKET_STATE, `STATE_LAST_ACK);
    settle;
    check(n_fin, snap + 16'h1);
    rd(`OFS_SOCKET_STATE, `STATE_RELEASED);
    delay = 4'd1;
    silent = 1'b1;
    load(`STATE_CONNECTED);
    wr(`OFS_COMMAND, `CODE_TEARDOWN);
    pulse(tcp_exp);
    rd(`OFS_SOCKET_STATE, `STATE_RELEASED);
    rd(`OFS_EVENT_FLAGS, 8'h08);
    silent = 1'b0;
    load(`STATE_CONNECTED);
    snap = n_fin;
    wr(`OFS_COMMAND, `CODE_CLOSE);
    rd(`OFS_SOCKET_STATE, `STATE_RELEASED);
    check(n_fin, snap);
    load(`STATE_CONNECTED);
    pulse(rx_rst_seen);
    rd(`OFS_SOCKET_STATE, `STATE_RELEASED);
    check({8'h00, socket_state}, {8'h00, `STATE_RELEASED});
    sock_mode = mode_udp;
    load(8'h22);
    wr(`OFS_COMMAND, `CODE_TEARDOWN);
    rd(`OFS_SOCKET_STATE, 8'h22);
    snap = n_keep;
    wr(`OFS_COMMAND, `CODE_KEEPALIVE);
    check(n_keep, snap);
    snap = n_res;
    wr(`OFS_COMMAND, `CODE_SEND);
    settle;
    check(n_res, snap + 16'h1);
    rd(`OFS_EVENT_FLAGS, 8'h10);
    check({15'h0, preset_seen}, 16'h0);
    wr(`OFS_EVENT_FLAGS, 8'hff);
    snap = n_tx;
    wr(`OFS_COMMAND, `CODE_SEND_PRESET);
    settle;
    check(n_tx, snap + 16'h1);
    check({15'h0, preset_seen}, 16'h1);
    rd(`OFS_EVENT_FLAGS, 8'h10);
    check(n_res - snap, n_tx - 16'h1 - snap);
    sock_mode = mode_tcp;
    load(`STATE_CONNECTED);
    snap = n_tx;
    wr(`OFS_COMMAND, `CODE_SEND_PRESET);
    check(n_tx, snap);
    snap = n_keep;
    wr(`OFS_COMMAND, `CODE_KEEPALIVE);
    settle;
    check(n_keep, snap + 16'h1);
    check({8'h00, keep_len}, {8'h00, `KEEPALIVE_BYTES});
    rd(`OFS_SOCKET_STATE, `STATE_CONNECTED);
    silent = 1'b1;
    wr(`OFS_COMMAND, `CODE_KEEPALIVE);
    pulse(tcp_exp);
    rd(`OFS_SOCKET_STATE, `STATE_RELEASED);
    rd(`OFS_EVENT_FLAGS, 8'h08);
    silent = 1'b0;
    rx_read_pointer = 16'h1234;
    snap = n_rel;
    wr(`OFS_COMMAND, `CODE_RECEIVE_DONE);
    check(n_rel, snap + 16'h1);
    check(done_ptr, 16'h1234);
    wr(`OFS_EVENT_FLAGS, 8'hff);
    pulse(rx_data_seen);
    rd(`OFS_EVENT_FLAGS, 8'h04);
    wr(`OFS_EVENT_FLAGS, 8'hff);
    pulse(res_exp);
    rd(`OFS_EVENT_FLAGS, 8'h08);
    wr(`OFS_EVENT_MASK, 8'h00);
    wr(`OFS_EVENT_FLAGS, 8'hff);
    pulse(rx_data_seen);
    rd(`OFS_EVENT_FLAGS, 8'h00);
    rd(`OFS_EVENT_MASK, 8'h00);
    conclude;
  end
endmodule
`default_nettype wire
